// >>> fds_pkg.sv
// package of constants and types for the fieldbus slave state machine and its master end
// ****************************************************************
// ****************************************************************
package fds_pkg;
   // telegram kinds carried over the link
   typedef enum logic [2:0] {
      FDS_TG_NONE = 3'h0,
      FDS_TG_PRM  = 3'h1,
      FDS_TG_CFG  = 3'h2,
      FDS_TG_DATA = 3'h3,
      FDS_TG_DIAG = 3'h4
   } fds_tg_t;
   // slave states, one-hot
   typedef enum logic [4:0] {
      FDS_S_BAUD = 5'h01,
      FDS_S_PRM  = 5'h02,
      FDS_S_CFG  = 5'h04,
      FDS_S_DX   = 5'h08,
      FDS_S_BOOT = 5'h10
   } fds_st_t;
   // master states, one-hot
   typedef enum logic [3:0] {
      FDS_M_IDLE = 4'h1,
      FDS_M_SEND = 4'h2,
      FDS_M_WAIT = 4'h4,
      FDS_M_GAP  = 4'h8
   } fds_mst_t;
   localparam logic [7:0] FDS_ADDR_MAX = 8'h7D;  // highest station address 125
   localparam logic [7:0] FDS_ADDR_BOOT = 8'hFF;
   localparam logic [7:0] FDS_ADDR_RST = 8'h7E;   // value before sampling
   localparam int FDS_CLK_MHZ = 125;
   localparam int FDS_BAUD_MBIT = 12;
   // clocks per bit at the fastest rate, rounded down
   localparam int FDS_BIT_CYC = FDS_CLK_MHZ / FDS_BAUD_MBIT;
   localparam int FDS_BAUD_LOCK = 4;              // idle bit times before baud is found
   localparam int FDS_WD_US = 100;                // bus watchdog time in microseconds
   localparam int FDS_WD_CYC = FDS_WD_US * FDS_CLK_MHZ;
   localparam int FDS_REPLY_CYC = 64;             // master waits this long for an answer
   localparam int FDS_C2_MAX = 8;                 // class 2 master cycles at most
   localparam logic [15:0] FDS_IDENT = 16'hA5C3;  // arbitrary identification value
   localparam logic [7:0] FDS_CFG_RST = 8'h00;
endpackage

// >>> fds_if.sv
// interface joining master end and slave end of the fieldbus link
`timescale 1ns/10ps
interface fds_if;
   logic req_vld;          // master request strobe, one cycle
   logic [7:0] req_addr;   // destination station address
   logic [2:0] req_kind;   // telegram kind
   logic [15:0] req_data;  // payload
   logic req_cls2;         // request comes from a class 2 master
   logic rsp_vld;          // slave answer strobe, one cycle
   logic [2:0] rsp_kind;
   logic [15:0] rsp_data;
   modport master (output req_vld, req_addr, req_kind, req_data, req_cls2,
                   input rsp_vld, rsp_kind, rsp_data);
   modport slave (input req_vld, req_addr, req_kind, req_data, req_cls2,
                  output rsp_vld, rsp_kind, rsp_data);
endinterface // fds_if

// >>> fds_slave.sv
// slave end: baud search, parameter, configuration and data exchange states
`timescale 1ns/10ps
module fds_slave
   import fds_pkg::*;
#(
   parameter int WD_CYC = FDS_WD_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link
   fds_if.slave bus,
   // user side
   input wire logic [7:0] addr_sel,
   input wire logic [15:0] in_data,
   output logic [15:0] out_data,
   output logic out_vld,
   output logic [7:0] cfg_layout,
   output logic online,
   output logic led_on,
   output logic wd_fault
);
   typedef struct packed {
      fds_st_t st;
      logic [7:0] addr;
      logic sampled;
      logic [7:0] cfg;
      logic [3:0] baud_cnt;
      logic [31:0] wd_cnt;
      logic [3:0] bit_cnt;
      logic rsp_vld;
      logic [2:0] rsp_kind;
      logic [15:0] rsp_data;
      logic [15:0] out_data;
      logic out_vld;
      logic fault;
   } fds_slv_t;

   fds_slv_t s_q;
   fds_slv_t s_d;
   logic mine;

   // telegram is for this station (never in bootstrap)
   assign mine = bus.req_vld && s_q.sampled && (bus.req_addr == s_q.addr)
                 && (s_q.addr <= FDS_ADDR_MAX);

   // next state of the slave
   always_comb begin
      s_d = s_q;
      s_d.rsp_vld = 1'b0;
      s_d.out_vld = 1'b0;
      // sample the selector once after reset
      if (!s_q.sampled) begin
         s_d.sampled = 1'b1;
         s_d.addr = addr_sel;
         if (addr_sel == FDS_ADDR_BOOT) begin
            s_d.st = FDS_S_BOOT;
         end
      end else begin
         case (s_q.st)
            FDS_S_BAUD: begin
               // a quiet line for several bit times at the top rate locks the baud
               if (bus.req_vld) begin
                  s_d.baud_cnt = 4'h0;
                  s_d.bit_cnt = 4'h0;
               end else if (s_q.bit_cnt == 4'(FDS_BIT_CYC - 1)) begin
                  s_d.bit_cnt = 4'h0;
                  s_d.baud_cnt = s_q.baud_cnt + 4'h1;
                  if (s_q.baud_cnt == 4'(FDS_BAUD_LOCK - 1)) begin
                     s_d.st = FDS_S_PRM;
                  end
               end else begin
                  s_d.bit_cnt = s_q.bit_cnt + 4'h1;
               end
            end
            FDS_S_PRM: begin
               // any parameter telegram is enough, payload not needed
               if (mine && bus.req_kind == FDS_TG_PRM) begin
                  s_d.st = FDS_S_CFG;
                  s_d.rsp_vld = 1'b1;
                  s_d.rsp_kind = FDS_TG_PRM;
                  s_d.rsp_data = FDS_IDENT;
               end
            end
            FDS_S_CFG: begin
               if (mine && bus.req_kind == FDS_TG_CFG) begin
                  s_d.cfg = bus.req_data[7:0];
                  s_d.st = FDS_S_DX;
                  s_d.rsp_vld = 1'b1;
                  s_d.rsp_kind = FDS_TG_CFG;
                  s_d.rsp_data = {8'h00, bus.req_data[7:0]};
               end else if (mine && bus.req_kind == FDS_TG_PRM) begin
                  s_d.rsp_vld = 1'b1; // repeated parameters restart configuration
                  s_d.rsp_kind = FDS_TG_PRM;
                  s_d.rsp_data = FDS_IDENT;
               end
            end
            FDS_S_DX: begin
               if (mine && bus.req_kind == FDS_TG_DATA) begin
                  s_d.out_data = bus.req_data;
                  s_d.out_vld = 1'b1;
                  s_d.rsp_vld = 1'b1;
                  s_d.rsp_kind = FDS_TG_DATA;
                  s_d.rsp_data = in_data;
               end else if (mine && bus.req_kind == FDS_TG_PRM) begin
                  s_d.st = FDS_S_CFG;
                  s_d.rsp_vld = 1'b1;
                  s_d.rsp_kind = FDS_TG_PRM;
                  s_d.rsp_data = FDS_IDENT;
               end
            end
            FDS_S_BOOT: begin
               s_d.st = FDS_S_BOOT;
            end
            default: begin
               s_d.st = FDS_S_BAUD;
            end
         endcase
         // diagnosis answered in every on-line state
         if (mine && bus.req_kind == FDS_TG_DIAG && s_q.st != FDS_S_BAUD) begin
            s_d.rsp_vld = 1'b1;
            s_d.rsp_kind = FDS_TG_DIAG;
            s_d.rsp_data = {s_q.fault, 2'b00, s_q.st, s_q.cfg};
         end
         // bus watchdog while exchanging data
         if (s_q.st == FDS_S_DX) begin
            if (mine) begin
               s_d.wd_cnt = 32'h0;
            end else if (s_q.wd_cnt == 32'(WD_CYC - 1)) begin
               s_d.wd_cnt = 32'h0;
               s_d.st = FDS_S_PRM;
               s_d.fault = 1'b1;
            end else begin
               s_d.wd_cnt = s_q.wd_cnt + 32'h1;
            end
         end else begin
            s_d.wd_cnt = 32'h0;
         end
         // fault stays until parameters accepted again
         if (s_q.st == FDS_S_PRM && s_d.st == FDS_S_CFG) begin
            s_d.fault = 1'b0;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q <= '{st: FDS_S_BAUD, addr: FDS_ADDR_RST, cfg: FDS_CFG_RST,
                  rsp_kind: FDS_TG_NONE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the register
   assign bus.rsp_vld = s_q.rsp_vld;
   assign bus.rsp_kind = s_q.rsp_kind;
   assign bus.rsp_data = s_q.rsp_data;
   assign out_data = s_q.out_data;
   assign out_vld = s_q.out_vld;
   assign cfg_layout = s_q.cfg;
   assign online = s_q.st[3];
   assign led_on = s_q.sampled & ~s_q.st[4];
   assign wd_fault = s_q.fault;
endmodule // fds_slave

// >>> fds_master.sv
// master end: parameters, configuration, then cyclic data with timeout watch
`timescale 1ns/10ps
module fds_master
   import fds_pkg::*;
#(
   parameter int GAP_CYC = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link
   fds_if.master bus,
   // user side
   input wire logic enable,
   input wire logic [7:0] slave_addr,
   input wire logic [7:0] cfg_in,
   input wire logic [15:0] tx_data,
   input wire logic diag_req,
   input wire logic cls2_req,
   output logic [15:0] rx_data,
   output logic rx_vld,
   output logic slave_fail,
   output logic in_exchange
);
   typedef struct packed {
      fds_mst_t st;
      fds_tg_t kind;
      logic phase_dx;
      logic phase_cfg;
      logic [7:0] cnt;
      logic [3:0] c2_cnt;
      logic req_vld;
      logic cls2;
      logic [7:0] addr;
      logic [15:0] data;
      logic [15:0] rx;
      logic rx_vld;
      logic fail;
   } fds_mas_t;

   fds_mas_t m_q;
   fds_mas_t m_d;

   // next state of the master
   always_comb begin
      m_d = m_q;
      m_d.req_vld = 1'b0;
      m_d.rx_vld = 1'b0;
      case (m_q.st)
         FDS_M_IDLE: begin
            if (enable) begin
               m_d.st = FDS_M_SEND;
               // class 2 ownership is limited to a few cycles
               m_d.cls2 = cls2_req && (m_q.c2_cnt < 4'(FDS_C2_MAX));
               m_d.c2_cnt = m_d.cls2 ? m_q.c2_cnt + 4'h1 : 4'h0;
               if (diag_req) begin
                  m_d.kind = FDS_TG_DIAG;
               end else if (m_q.phase_dx) begin
                  m_d.kind = FDS_TG_DATA;
               end else if (m_q.phase_cfg) begin
                  m_d.kind = FDS_TG_CFG;
               end else begin
                  m_d.kind = FDS_TG_PRM;
               end
            end
         end
         FDS_M_SEND: begin
            // address and payload held in flops for the whole request
            m_d.req_vld = 1'b1;
            m_d.addr = slave_addr;
            m_d.data = (m_q.kind == FDS_TG_CFG) ? {8'h00, cfg_in} : tx_data;
            m_d.cnt = 8'h00;
            m_d.st = FDS_M_WAIT;
         end
         FDS_M_WAIT: begin
            if (bus.rsp_vld) begin
               m_d.st = FDS_M_GAP;
               m_d.cnt = 8'h00;
               m_d.fail = 1'b0;
               if (bus.rsp_kind == FDS_TG_PRM) begin
                  m_d.phase_cfg = 1'b1;
                  m_d.phase_dx = 1'b0;
               end else if (bus.rsp_kind == FDS_TG_CFG) begin
                  m_d.phase_dx = 1'b1;
               end
               m_d.rx = bus.rsp_data;
               m_d.rx_vld = 1'b1;
            end else if (m_q.cnt == 8'(FDS_REPLY_CYC - 1)) begin
               // no answer: slave lost, start over with parameters
               m_d.fail = 1'b1;
               m_d.phase_cfg = 1'b0;
               m_d.phase_dx = 1'b0;
               m_d.st = FDS_M_GAP;
               m_d.cnt = 8'h00;
            end else begin
               m_d.cnt = m_q.cnt + 8'h01;
            end
         end
         FDS_M_GAP: begin
            // fixed gap keeps traffic strictly cyclic
            if (m_q.cnt == 8'(GAP_CYC - 1)) begin
               m_d.st = FDS_M_IDLE;
            end else begin
               m_d.cnt = m_q.cnt + 8'h01;
            end
         end
         default: begin
            m_d.st = FDS_M_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         m_q <= '{st: FDS_M_IDLE, kind: FDS_TG_NONE, default: '0};
      end else begin
         m_q <= m_d;
      end
   end

   // request fields: data held from the registered kind
   assign bus.req_vld = m_q.req_vld;
   assign bus.req_addr = m_q.addr;
   assign bus.req_kind = m_q.kind;
   assign bus.req_data = m_q.data;
   assign bus.req_cls2 = m_q.cls2;
   assign rx_data = m_q.rx;
   assign rx_vld = m_q.rx_vld;
   assign slave_fail = m_q.fail;
   assign in_exchange = m_q.phase_dx;
endmodule // fds_master

// >>> fds_props.sv
// checker of the link between the master end and the slave end
`timescale 1ns/10ps
module fds_props
   import fds_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link
   input wire logic req_vld,
   input wire logic [7:0] req_addr,
   input wire logic [2:0] req_kind,
   input wire logic [15:0] req_data,
   input wire logic req_cls2,
   input wire logic rsp_vld,
   input wire logic [2:0] rsp_kind,
   input wire logic [15:0] rsp_data
);
   // ***
   // helper state
   // ***
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   logic [7:0] up_q;
   logic cfg_q;
   // cycles since reset, and a configuration answer seen since the last parameter answer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         up_q <= 8'h00;
         cfg_q <= 1'b0;
      end else begin
         if (up_q != 8'hFF)
            up_q <= up_q + 8'h01;
         if (rsp_vld && rsp_kind == FDS_TG_CFG)
            cfg_q <= 1'b1;
         else if (rsp_vld && rsp_kind == FDS_TG_PRM)
            cfg_q <= 1'b0;
      end
   end
   // ***
   // properties
   // ***
   AST_REPLY_ONLY: assert property (rsp_vld |-> $past(req_vld))
      else $error("answer without request");
   AST_RSP_PULSE: assert property (rsp_vld |=> !rsp_vld)
      else $error("answer longer than one cycle");
   AST_ADDR_RANGE: assert property (rsp_vld |-> $past(req_addr) <= FDS_ADDR_MAX)
      else $error("answer to address above range");
   AST_BAUD_QUIET: assert property (rsp_vld |-> up_q >= 8'h28)
      else $error("answer during baud search");
   AST_PRM_IDENT: assert property (rsp_vld && rsp_kind == FDS_TG_PRM |-> rsp_data == FDS_IDENT)
      else $error("wrong identification");
   AST_DX_AFTER_CFG: assert property (rsp_vld && rsp_kind == FDS_TG_DATA |-> cfg_q)
      else $error("data answer before configuration");
   AST_DIAG_STATE: assert property (rsp_vld && rsp_kind == FDS_TG_DIAG |->
      rsp_data[12:8] inside {5'h02, 5'h04, 5'h08})
      else $error("diagnosis state not valid");
   AST_REQ_SPACED: assert property (req_vld |=> !req_vld [*8])
      else $error("requests too close");
endmodule // fds_props

// >>> fieldbus_dp_slave_state_machine_tb.sv
// self-checking bench: master end and slave end joined over the link
`timescale 1ns/10ps
module fieldbus_dp_slave_state_machine_tb import fds_pkg::*;;
   // ***
   // stimulus and wiring
   // ***
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic enable = 1'b0;
   logic diag_req = 1'b0;
   logic cls2_req = 1'b0;
   logic [7:0] addr_sel = 8'h05;
   logic [7:0] slave_addr = 8'h05;
   logic [7:0] cfg_in = 8'h35;
   logic [15:0] tx_data = 16'h1234;
   logic [15:0] in_data = 16'hABCD;
   logic [15:0] out_data, rx_data;
   logic [7:0] cfg_layout;
   logic out_vld, online, led_on, wd_fault, rx_vld, slave_fail, in_exchange;
   int fails = 0;
   int n_tests = 0;
   fds_if link ();
   fds_slave #(.WD_CYC(200)) fds_slave_i (.sys_clk(sys_clk), .reset(reset), .bus(link.slave),
      .addr_sel(addr_sel), .in_data(in_data), .out_data(out_data), .out_vld(out_vld),
      .cfg_layout(cfg_layout), .online(online), .led_on(led_on), .wd_fault(wd_fault));
   fds_master fds_master_i (.sys_clk(sys_clk), .reset(reset), .bus(link.master),
      .enable(enable), .slave_addr(slave_addr), .cfg_in(cfg_in), .tx_data(tx_data),
      .diag_req(diag_req), .cls2_req(cls2_req), .rx_data(rx_data), .rx_vld(rx_vld),
      .slave_fail(slave_fail), .in_exchange(in_exchange));
   fds_props fds_props_i (.sys_clk(sys_clk), .reset(reset), .req_vld(link.req_vld),
      .req_addr(link.req_addr), .req_kind(link.req_kind), .req_data(link.req_data),
      .req_cls2(link.req_cls2), .rsp_vld(link.rsp_vld), .rsp_kind(link.rsp_kind),
      .rsp_data(link.rsp_data));
   // 125 MHz clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // ***
   // shared tasks
   // ***
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return online;
         1: return out_vld;
         2: return rx_vld;
         3: return link.rsp_vld && link.rsp_kind == FDS_TG_DIAG;
         4: return slave_fail;
         default: return !online;
      endcase
   endfunction
   // bounded wait, sampled at the falling edge
   task automatic wait_on(input int s, input int lim);
      int k;
      for (k = 0; k < lim; k++) begin
         @(negedge sys_clk);
         if (pick(s) === 1'b1)
            break;
      end
      if (k == lim) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         complete_run();
      end
   endtask
   task automatic do_reset(input logic [7:0] a, input logic [7:0] c);
      @(posedge sys_clk);
      reset <= 1'b1;
      enable <= 1'b0;
      addr_sel <= a;
      slave_addr <= a;
      cfg_in <= c;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      enable <= 1'b1;
   endtask
   // ***
   // scenarios
   // ***
   task automatic t_start(input logic [7:0] a, input logic [7:0] c);
      do_reset(a, c);
      wait_on(0, 3000);
      chk({8'h00, cfg_layout}, {8'h00, c});
      chk1(led_on, 1'b1);
      wait_on(1, 300);
      chk(out_data, tx_data);
      chk1(in_exchange, 1'b1);
      wait_on(2, 300);
      chk(rx_data, in_data);
      $display("start done");
   endtask
   task automatic t_diag();
      @(posedge sys_clk);
      diag_req <= 1'b1;
      wait_on(3, 400);
      chk(link.rsp_data, {3'h0, FDS_S_DX, cfg_in});
      @(posedge sys_clk);
      diag_req <= 1'b0;
      $display("diag done");
   endtask
   task automatic t_hold();
      @(posedge sys_clk);
      addr_sel <= 8'h09;
      cls2_req <= 1'b1;
      wait_on(1, 300);
      wait_on(1, 300);
      chk1(online, 1'b1);
      @(posedge sys_clk);
      cls2_req <= 1'b0;
      $display("hold done");
   endtask
   task automatic t_lost();
      @(posedge sys_clk);
      slave_addr <= 8'h06;
      wait_on(4, 300);
      wait_on(5, 400);
      chk1(wd_fault, 1'b1);
      $display("lost done");
   endtask
   task automatic t_refuse(input logic [7:0] a);
      int n;
      n = 0;
      do_reset(a, 8'h11);
      repeat (600) begin
         @(negedge sys_clk);
         if (link.rsp_vld !== 1'b0 || online !== 1'b0)
            n++;
      end
      chk(n[15:0], 16'h0000);
      if (a == 8'hFF)
         chk1(led_on, 1'b0);
      $display("refuse done");
   endtask
   // main sequence
   initial begin
      t_start(8'h05, 8'h35);
      t_diag();
      t_hold();
      t_lost();
      t_start(8'h07, 8'hC2);
      t_refuse(8'hFF);
      t_refuse(8'h7E);
      complete_run();
   end
   // run limit
   initial begin
      repeat (100000) @(posedge sys_clk);
      fails++;
      complete_run();
   end
endmodule // fieldbus_dp_slave_state_machine_tb
